/* File: rmii_pin_block.sv */
// rmii side pins, reset straps, interrupt and led of an ethernet transceiver
// assumes an axi4-lite master on clk and an rmii mac clocked by refClkIn
// Operation
// - latch three mode straps at reset release
// - latch broadcast disable from refclock pin
// - latch isolate setting from receive-error pin
// - latch tree test select from interrupt pin
// - latch autoneg strap into control bit 12
// - drive carrier-sense/data-valid on mode-bit2 pin
// - drive reference clock in 25 MHz mode
// - leave reference clock pin undriven in 50M
// - drive receive error on isolate strap pin
// - interrupt pin open drain, drives low only
// - send two receive bits per clock
module rmii_pin_block
   import rmii_strap_pkg::*;
#(
   parameter int BLINK = BLINK_CYCLES
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic irq,
   input wire logic refClkIn,
   input wire logic txEn,
   input wire logic [1:0] txd,
   input wire logic cfgMode0In,
   input wire logic cfgMode1In,
   input wire logic crsDvIn,
   output logic crsDvOut,
   output logic crsDvOe,
   input wire logic refClkPinIn,
   output logic refClkPinOut,
   output logic refClkPinOe,
   input wire logic rxErIn,
   output logic rxErOut,
   output logic rxErOe,
   input wire logic irqPinIn,
   output logic irqPinOut,
   output logic irqPinOe,
   input wire logic ledPinIn,
   output logic ledPinOut,
   output logic ledPinOe,
   output logic [1:0] rxd
);
   logic [10:0] pinsS;
   logic refS;
   dibit_type txS;
   logic refPrev_r;
   logic refEdge;
   logic [1:0] strapCnt_r;
   logic strapDone_r;
   strap_type strap_r;
   logic loop_r;
   logic linkUp_r;
   logic forceErr_r;
   logic iso_r;
   logic aneg_r;
   logic [1:0] ledMode_r;
   logic [NEV-1:0] stat_r;
   logic [NEV-1:0] mask_r;
   logic [NEV-1:0] events;
   logic [NEV-1:0] clrBits;
   logic linkPrev_r;
   tx_state_type txState_r;
   logic [7:0] txShift_r;
   logic [1:0] dibitCnt_r;
   logic [7:0] txByte_r;
   logic [15:0] txBytes_r;
   logic rxActive_r;
   logic ledLevel;
   logic wrFire;
   logic wrHit;
   logic [31:0] rdNxt;
   logic rdHit;
   logic mode50;

   // every pin level crosses into clk before use
   sync2 #(.W(11)) pinSync (
      .clk(clk),
      .sys_rst(sys_rst),
      .din({refClkIn, txEn, txd, cfgMode0In, cfgMode1In, crsDvIn, refClkPinIn,
            rxErIn, irqPinIn, ledPinIn}),
      .dout(pinsS)
   );
   assign refS = pinsS[10];
   assign txS = pinsS[9:7];
   assign refEdge = refS & ~refPrev_r;
   assign mode50 = (strap_r.mode == MODE_RMII_50M);

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         refPrev_r <= 1'b0;
      end else begin
         refPrev_r <= refS;
      end
   end

   // strap pins are read only after the synchronisers hold post-reset levels
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         strapCnt_r <= '0;
         strapDone_r <= 1'b0;
         strap_r <= '0;
      end else if (!strapDone_r) begin
         strapCnt_r <= strapCnt_r + 2'h1;
         if (strapCnt_r == STRAP_WAIT) begin
            strapDone_r <= 1'b1;
            strap_r.mode <= {pinsS[4], pinsS[5], pinsS[6]};
            strap_r.bcastDisable <= pinsS[3];
            strap_r.isolate <= pinsS[2];
            strap_r.treeTestN <= pinsS[1];
            strap_r.autoneg <= pinsS[0];
         end
      end
   end

   // transmit dibits arrive lsb first on each reference clock rise
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         txState_r <= TX_IDLE;
         txShift_r <= '0;
         dibitCnt_r <= '0;
         txByte_r <= '0;
         txBytes_r <= '0;
      end else if (refEdge && strapDone_r) begin
         unique case (txState_r)
            TX_IDLE: begin
               dibitCnt_r <= '0;
               if (txS.en) begin
                  txState_r <= TX_BUSY;
                  txShift_r <= {txS.d, txShift_r[7:2]};
                  dibitCnt_r <= 2'h1;
               end
            end
            TX_BUSY: begin
               if (txS.en) begin
                  txShift_r <= {txS.d, txShift_r[7:2]};
                  dibitCnt_r <= dibitCnt_r + 2'h1;
                  if (dibitCnt_r == 2'h3) begin
                     txByte_r <= {txS.d, txShift_r[7:2]};
                     txBytes_r <= txBytes_r + 16'h1;
                  end
               end else begin
                  txState_r <= TX_IDLE;
               end
            end
         endcase
      end
   end

   // receive path loops transmit back; without a line side it is idle otherwise
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rxd <= '0;
         crsDvOut <= 1'b0;
         rxErOut <= 1'b0;
         rxActive_r <= 1'b0;
      end else if (refEdge) begin
         rxd <= (loop_r && txS.en && !iso_r) ? txS.d : 2'h0;
         crsDvOut <= loop_r && txS.en;
         rxErOut <= loop_r && txS.en && forceErr_r;
         rxActive_r <= loop_r && txS.en;
      end
   end

   // pins stay inputs until the straps are taken
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         crsDvOe <= 1'b0;
         rxErOe <= 1'b0;
         refClkPinOe <= 1'b0;
         refClkPinOut <= 1'b0;
         ledPinOe <= 1'b0;
         ledPinOut <= 1'b1;
         irqPinOe <= 1'b0;
         irqPinOut <= 1'b0;
         irq <= 1'b0;
      end else begin
         crsDvOe <= strapDone_r && !iso_r;
         rxErOe <= strapDone_r && !iso_r;
         refClkPinOut <= refS;
         refClkPinOe <= strapDone_r && !mode50;
         ledPinOe <= strapDone_r;
         ledPinOut <= ledLevel;
         irqPinOut <= 1'b0;
         irqPinOe <= strapDone_r && |(stat_r & mask_r);
         irq <= |(stat_r & mask_r);
      end
   end

   led_driver #(.BLINK(BLINK)) ledDrv (
      .clk(clk),
      .sys_rst(sys_rst),
      .ledMode(ledMode_r),
      .linkUp(linkUp_r),
      .activity(txS.en | rxActive_r),
      .ledLevel(ledLevel)
   );

   // events: tx start and end, rx end, link change
   always_comb begin
      events = '0;
      events[EV_TXSTART] = refEdge && strapDone_r && txState_r == TX_IDLE && txS.en;
      events[EV_TXEND] = refEdge && strapDone_r && txState_r == TX_BUSY && !txS.en;
      events[EV_RXEND] = refEdge && rxActive_r && !(loop_r && txS.en);
      events[EV_LINK] = linkUp_r != linkPrev_r;
   end

   // axi write: address and data taken together, one outstanding
   assign wrFire = awvalid && wvalid && !awready && !bvalid;
   assign wrHit = awaddr == ADDR_CTRL || awaddr == ADDR_LEDCFG || awaddr == ADDR_STAT ||
                  awaddr == ADDR_MASK;
   assign clrBits = (wrFire && awaddr == ADDR_STAT && wstrb[0]) ? wdata[NEV-1:0] : '0;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         awready <= 1'b0;
         wready <= 1'b0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else begin
         awready <= wrFire;
         wready <= wrFire;
         if (wrFire) begin
            bvalid <= 1'b1;
            bresp <= wrHit ? RESP_OKAY : RESP_SLVERR;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         loop_r <= 1'b0;
         linkUp_r <= 1'b0;
         forceErr_r <= 1'b0;
         iso_r <= 1'b0;
         aneg_r <= 1'b0;
         ledMode_r <= LED_LINKACT;
         mask_r <= '0;
      end else if (strapDone_r == 1'b0 && strapCnt_r == STRAP_WAIT) begin
         iso_r <= pinsS[2];
         aneg_r <= pinsS[0];
      end else if (wrFire) begin
         if (awaddr == ADDR_CTRL && wstrb[0]) begin
            loop_r <= wdata[CTRL_LOOP];
            linkUp_r <= wdata[CTRL_LINK];
            forceErr_r <= wdata[CTRL_RXERR];
         end
         if (awaddr == ADDR_CTRL && wstrb[1]) begin
            iso_r <= wdata[CTRL_ISO];
            aneg_r <= wdata[CTRL_ANEG];
         end
         if (awaddr == ADDR_LEDCFG && wstrb[0]) begin
            ledMode_r <= wdata[LED_MODE_LSB +: 2];
         end
         if (awaddr == ADDR_MASK && wstrb[0]) begin
            mask_r <= wdata[NEV-1:0];
         end
      end
   end

   // an event in the clearing cycle survives
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         stat_r <= '0;
         linkPrev_r <= 1'b0;
      end else begin
         stat_r <= (stat_r & ~clrBits) | events;
         linkPrev_r <= linkUp_r;
      end
   end

   // axi read
   always_comb begin
      rdNxt = '0;
      rdHit = 1'b1;
      unique case (araddr)
         ADDR_CTRL: begin
            rdNxt[CTRL_LOOP] = loop_r;
            rdNxt[CTRL_LINK] = linkUp_r;
            rdNxt[CTRL_RXERR] = forceErr_r;
            rdNxt[CTRL_ISO] = iso_r;
            rdNxt[CTRL_ANEG] = aneg_r;
         end
         ADDR_LEDCFG: rdNxt[LED_MODE_LSB +: 2] = ledMode_r;
         ADDR_STRAP: rdNxt[$bits(strap_type):0] = {strapDone_r, strap_r};
         ADDR_STAT: rdNxt[NEV-1:0] = stat_r;
         ADDR_MASK: rdNxt[NEV-1:0] = mask_r;
         ADDR_TXINFO: rdNxt[23:0] = {txBytes_r, txByte_r};
         default: rdHit = 1'b0;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end else begin
         arready <= arvalid && !arready && !rvalid;
         if (arvalid && !arready && !rvalid) begin
            rvalid <= 1'b1;
            rdata <= rdNxt;
            rresp <= rdHit ? RESP_OKAY : RESP_SLVERR;
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end
endmodule

/* File: rmii_strap_pkg.sv */
// constants, field positions and carrier types of the rmii pin and strap block
// assumes a single 125 MHz system clock and a sampled rmii reference clock
package rmii_strap_pkg;

   // system clock and blink timing
   localparam int CLK_HZ = 125_000_000;
   localparam int BLINK_MS = 50;
   localparam int BLINK_CYCLES = (CLK_HZ / 1000) * BLINK_MS;

   // register indices as printed, byte address is four times the index
   localparam logic [7:0] IDX_CTRL = 8'h00;
   localparam logic [7:0] IDX_LEDCFG = 8'h1f;
   localparam logic [7:0] ADDR_CTRL = {IDX_CTRL[5:0], 2'b00};
   localparam logic [7:0] ADDR_LEDCFG = {IDX_LEDCFG[5:0], 2'b00};
   localparam logic [7:0] ADDR_STRAP = 8'h04;
   localparam logic [7:0] ADDR_STAT = 8'h08;
   localparam logic [7:0] ADDR_MASK = 8'h0c;
   localparam logic [7:0] ADDR_TXINFO = 8'h10;

   // control and led configuration register fields
   localparam int CTRL_LOOP = 0;
   localparam int CTRL_LINK = 1;
   localparam int CTRL_RXERR = 2;
   localparam int CTRL_ISO = 10;
   localparam int CTRL_ANEG = 12;
   localparam int LED_MODE_LSB = 4;

   // interrupt status fields
   localparam int EV_TXSTART = 0;
   localparam int EV_TXEND = 1;
   localparam int EV_RXEND = 2;
   localparam int EV_LINK = 3;
   localparam int NEV = 4;

   // operating modes from the three mode straps
   localparam logic [2:0] MODE_RMII = 3'h1;
   localparam logic [2:0] MODE_RMII_50M = 3'h5;

   // strap capture waits for the pin synchronisers to fill
   localparam logic [1:0] STRAP_WAIT = 2'h3;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      LED_LINKACT = 2'h0,
      LED_ACT = 2'h1
   } led_mode_type;

   typedef enum logic [1:0] {
      TX_IDLE = 2'h1,
      TX_BUSY = 2'h2
   } tx_state_type;

   typedef struct packed {
      logic [2:0] mode;
      logic bcastDisable;
      logic isolate;
      logic treeTestN;
      logic autoneg;
   } strap_type;

   typedef struct packed {
      logic en;
      logic [1:0] d;
   } dibit_type;

endpackage

/* File: sync2.sv */
// two flip-flop synchroniser for a group of asynchronous levels
// assumes inputs are quasi static relative to clk
module sync2 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         meta_r <= '0;
         dout <= '0;
      end else begin
         meta_r <= din;
         dout <= meta_r;
      end
   end
endmodule

/* File: led_driver.sv */
// link and activity led level, pin low means lit
// assumes link and activity are levels on clk
module led_driver
   import rmii_strap_pkg::*;
#(
   parameter int BLINK = BLINK_CYCLES
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [1:0] ledMode,
   input wire logic linkUp,
   input wire logic activity,
   output logic ledLevel
);
   logic [31:0] blinkCnt_r;
   logic blink_r;
   logic ledNxt;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         blinkCnt_r <= '0;
         blink_r <= 1'b0;
      end else if (blinkCnt_r == 32'(BLINK - 1)) begin
         blinkCnt_r <= '0;
         blink_r <= ~blink_r;
      end else begin
         blinkCnt_r <= blinkCnt_r + 32'h1;
      end
   end

   always_comb begin
      ledNxt = 1'b1;
      if (ledMode == LED_LINKACT) begin
         ledNxt = activity ? blink_r : ~linkUp;
      end else if (ledMode == LED_ACT) begin
         ledNxt = activity ? blink_r : 1'b1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ledLevel <= 1'b1;
      end else begin
         ledLevel <= ledNxt;
      end
   end
endmodule

/* File: rmii_pin_block_monitor.sv */
// port assertions for the rmii pin, strap, interrupt and led block
// bound into rmii_pin_block; strap pins are held steady around reset release
module rmii_pin_block_monitor
   import rmii_strap_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic awready,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic irq,
   input wire logic refClkIn,
   input wire logic cfgMode0In,
   input wire logic cfgMode1In,
   input wire logic crsDvIn,
   input wire logic crsDvOut,
   input wire logic crsDvOe,
   input wire logic refClkPinOut,
   input wire logic refClkPinOe,
   input wire logic rxErIn,
   input wire logic rxErOe,
   input wire logic irqPinOut,
   input wire logic irqPinOe,
   input wire logic [1:0] rxd
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] cnt_r;
   logic m50_r;
   logic iso_r;
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // own strap copy, taken early since the pins stay still
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) cnt_r <= 3'h0;
      else if (cnt_r != 3'h6) cnt_r <= cnt_r + 3'h1;
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         m50_r <= 1'b0;
         iso_r <= 1'b0;
      end else if (cnt_r == 3'h1) begin
         m50_r <= {crsDvIn, cfgMode1In, cfgMode0In} == MODE_RMII_50M;
         iso_r <= rxErIn;
      end
   end
   aw_pulse_a: assert property (awready |=> !awready)
      else $error("write address ready longer than one cycle");
   write_resp_a: assert property (awready |-> wready && bvalid)
      else $error("write ready and response not together");
   resp_hold_a: assert property (bvalid && !bready |=> bvalid)
      else $error("write response dropped early");
   read_hold_a: assert property (rvalid && !rready |=> rvalid)
      else $error("read data dropped early");
   irq_pin_a: assert property ($rose(irq) |-> ##[0:2] irqPinOe && !irqPinOut)
      else $error("interrupt pin not pulled low");
   irq_release_a: assert property ($fell(irq) |-> ##[0:2] !irqPinOe)
      else $error("interrupt pin still pulled low");
   refclk_off_a: assert property (cnt_r >= 3'h2 && m50_r |-> !refClkPinOe)
      else $error("reference clock pin driven in 50 MHz mode");
   refclk_drive_a: assert property (cnt_r == 3'h6 && !m50_r |-> refClkPinOe)
      else $error("reference clock pin not driven");
   refclk_copy_a: assert property (refClkPinOe && $rose(refClkIn) |-> ##[1:5] refClkPinOut)
      else $error("reference clock output does not follow");
   rx_pins_a: assert property (cnt_r == 3'h6 |-> crsDvOe == !iso_r && rxErOe == !iso_r)
      else $error("receive pin enables disagree with isolate strap");
   rx_steady_a: assert property ($rose(refClkIn) && crsDvOut |-> $stable(rxd) [*2])
      else $error("receive dibit moved near the reference edge");
endmodule

bind rmii_pin_block rmii_pin_block_monitor rmii_pin_block_monitor_inst (.*);

/* File: rmii_mac_model.sv */
// mac side of the rmii link: free running reference clock, dibit transmit
// assumes the bench calls sendFrame from its main sequence
module rmii_mac_model (
   output logic refClkIn,
   output logic txEn,
   output logic [1:0] txd
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      refClkIn = 1'b0;
      txEn = 1'b0;
      txd = 2'h0;
      // phase kept apart from the system clock
      #3;
      forever #80 refClkIn = ~refClkIn;
   end
   task automatic sendFrame(input logic [7:0] b[$]);
      foreach (b[i]) begin
         for (int k = 0; k < 4; k++) begin
            @(posedge refClkIn);
            txEn <= 1'b1;
            txd <= b[i][2*k +: 2];
         end
      end
      @(posedge refClkIn);
      txEn <= 1'b0;
      // idle data is not held, so a stale dibit cannot pass
      txd <= ~txd;
   endtask
endmodule

/* File: tb.sv */
// self-checking bench for rmii_pin_block with a mac model and pin pulls
// assumes the checker is bound in; blink count shortened to 4
module tb
   import rmii_strap_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {
      logic w;
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] e;
      logic [1:0] r;
   } row_type;
   logic clk, sys_rst, awvalid, wvalid, bready, arvalid, rready, txEn;
   logic awready, wready, bvalid, arready, rvalid, irq, refClkIn;
   logic cfgMode0In, cfgMode1In, crsDvIn, crsDvOut, crsDvOe, refClkPinIn, refClkPinOut;
   logic refClkPinOe, rxErIn, rxErOut, rxErOe, irqPinIn, irqPinOut, irqPinOe;
   logic ledPinIn, ledPinOut, ledPinOe, strapCrs, strapBc, strapIso, strapLed;
   logic [7:0] awaddr, araddr, rxSr;
   logic [31:0] wdata, rdata, got;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, txd, rxd, rs;
   logic [7:0] frame[$];
   row_type rows[5];
   int fails = 0;
   int nTests = 0;
   int ledFlips = 0;
`define CHK(nm, e, s) begin nTests++; if ((s) !== (e)) begin fails++; \
   $display("unexpected %s expected %h seen %h", nm, e, s); end end
   // pins resolved from enables and board pulls
   assign crsDvIn = crsDvOe ? crsDvOut : strapCrs;
   assign refClkPinIn = refClkPinOe ? refClkPinOut : strapBc;
   assign rxErIn = rxErOe ? rxErOut : strapIso;
   assign irqPinIn = irqPinOe ? irqPinOut : 1'b1;
   assign ledPinIn = ledPinOe ? ledPinOut : strapLed;
   rmii_pin_block #(.BLINK(4)) rmii_pin_block_inst (.*);
   rmii_mac_model rmii_mac_model_inst (.*);
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge refClkIn) if (crsDvOut === 1'b1) rxSr <= {rxd, rxSr[7:2]};
   always @(ledPinOut) ledFlips++;
   task automatic testDone();
      $display("comparisons %0d mismatches %0d", nTests, fails);
      if (fails == 0 && nTests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #50us;
      fails++;
      testDone();
   end
   task automatic axWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      r = bresp;
      bready <= 1'b0;
   endtask
   task automatic axRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   task automatic acc(input row_type x);
      if (x.w) axWrite(x.a, x.d, rs);
      axRead(x.a, got, rs);
      `CHK("rdata", x.e, got)
      `CHK("rresp", x.r, rs)
   endtask
   task automatic newReset(input logic [3:0] s);
      sys_rst <= 1'b1;
      {strapCrs, strapBc, strapIso, strapLed} <= s;
      repeat (20) @(posedge clk);
      `CHK("rstled", 1'b1, ledPinOut)
      sys_rst <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
   initial begin
      sys_rst = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      {awaddr, araddr, wdata} = 48'h0;
      wstrb = 4'hf;
      {cfgMode1In, cfgMode0In} = 2'h1;
      {strapCrs, strapBc, strapIso, strapLed} = 4'h5;
      rows[0] = '{1'b0, ADDR_CTRL, 32'h0, 32'h1000, RESP_OKAY};
      rows[1] = '{1'b0, ADDR_STRAP, 32'h0, 32'h9b, RESP_OKAY};
      rows[2] = '{1'b1, ADDR_LEDCFG, 32'h20, 32'h20, RESP_OKAY};
      rows[3] = '{1'b0, 8'h40, 32'h0, 32'h0, RESP_SLVERR};
      rows[4] = '{1'b1, ADDR_MASK, 32'hf, 32'hf, RESP_OKAY};
      newReset(4'h5);
      `CHK("refoe", 1'b1, refClkPinOe)
      foreach (rows[i]) acc(rows[i]);
      axWrite(8'h40, 32'h1, rs);
      `CHK("bresp", RESP_SLVERR, rs)
      axWrite(ADDR_CTRL, 32'h1002, rs);
      repeat (4) @(posedge clk);
      `CHK("led", 1'b1, ledPinOut)
      axWrite(ADDR_LEDCFG, 32'h0, rs);
      repeat (4) @(posedge clk);
      `CHK("led", 1'b0, ledPinOut)
      axWrite(ADDR_CTRL, 32'h1003, rs);
      axWrite(ADDR_STAT, 32'hf, rs);
      ledFlips = 0;
      frame = {8'h5a, 8'hc3};
      rmii_mac_model_inst.sendFrame(frame);
      repeat (12) @(posedge clk);
      `CHK("rxd", 8'hc3, rxSr)
      `CHK("blink", 1'b1, ledFlips > 0)
      `CHK("irq", 1'b1, irq)
      `CHK("irqpin", 1'b1, irqPinOe)
      acc(row_type'{1'b0, ADDR_TXINFO, 32'h0, 32'h2c3, RESP_OKAY});
      axRead(ADDR_STAT, got, rs);
      `CHK("stat", 32'h3, got & 32'h3)
      axWrite(ADDR_STAT, 32'hf, rs);
      acc(row_type'{1'b0, ADDR_STAT, 32'h0, 32'h0, RESP_OKAY});
      `CHK("irq", 1'b0, irq)
      axWrite(ADDR_MASK, 32'h0, rs);
      frame = {8'h01};
      rmii_mac_model_inst.sendFrame(frame);
      repeat (12) @(posedge clk);
      `CHK("masked", 1'b0, irqPinOe)
      axRead(ADDR_STAT, got, rs);
      `CHK("stat", 1'b1, got[EV_TXEND])
      {cfgMode1In, cfgMode0In} <= 2'h1;
      newReset(4'ha);
      `CHK("refoe", 1'b0, refClkPinOe)
      `CHK("crsoe", 1'b0, crsDvOe)
      acc(row_type'{1'b0, ADDR_STRAP, 32'h0, 32'hd6, RESP_OKAY});
      acc(row_type'{1'b0, ADDR_CTRL, 32'h0, 32'h400, RESP_OKAY});
      testDone();
   end
endmodule
